// *** dv/sva_link_assertions.sv ***
// Checker for the cyclic image link between controller and device ends.
// Assumes both images are registered on pclk and fp_mode changes only under a null command.
module sva_link_chk
  import sva_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        fp_mode,
  input wire logic [15:0] out_img [OUT_WORDS],
  input wire logic [15:0] in_img  [IN_WORDS]
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [15:0] cmd  = fp_mode ? out_img[FP_CMD_W] : out_img[INT_CMD_W];
  wire logic [15:0] stat = fp_mode ? in_img[FP_STAT_W] : in_img[INT_STAT_W];
  wire logic [15:0] rv0  = fp_mode ? in_img[FP_RVAL_W] : in_img[INT_RVAL_W];
  wire logic [15:0] rv1  = fp_mode ? in_img[FP_RVAL_W + 1] : in_img[INT_RVAL_W + 1];
  wire logic [15:0] rv2  = fp_mode ? in_img[FP_RVAL_W + 2] : in_img[INT_RVAL_W + 2];
  wire logic [15:0] rv9  = fp_mode ? in_img[FP_RVAL_W + 9] : in_img[INT_RVAL_W + 9];
  wire logic [47:0] name = fp_mode ?
    {out_img[FP_NAME_W], out_img[FP_NAME_W + 1], out_img[FP_NAME_W + 2]} :
    {out_img[INT_NAME_W], out_img[INT_NAME_W + 1], out_img[INT_NAME_W + 2]};
  wire logic        hit  = (name == VAR_NAME[0]) || (name == VAR_NAME[1]) ||
                           (name == VAR_NAME[2]) || (name == VAR_NAME[3]);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A command is taken only on the edge where the word differs from the last one.
  sequence s_new;
    cmd != $past(cmd) && cmd != CMD_NULL;
  endsequence
  sequence s_write;
    s_new ##0 cmd == CMD_WRITE;
  endsequence

  property p_null_stat; cmd == CMD_NULL |=> stat == ST_NULL && rv0 == 16'h0000; endproperty
  property p_answer; s_new |=> stat != ST_NULL; endproperty
  property p_bad_cmd; s_new ##0 cmd > CMD_WRITE |=> stat == ST_CMD; endproperty
  property p_bad_name; s_new ##0 (cmd <= CMD_WRITE && !hit) |=> stat == ST_NAME; endproperty
  property p_prot; s_write ##0 name == VAR_NAME[0] |=> stat == ST_PROT; endproperty
  property p_hold; cmd != CMD_NULL && $stable(cmd) |=> $stable(stat) && $stable(rv0); endproperty
  property p_no_rval; cmd != CMD_READ |=> rv0 == 16'h0000 && rv9 == 16'h0000; endproperty
  property p_int_len; s_new ##0 cmd == CMD_READ && name == VAR_NAME[3] |=> rv1 == 16'h0000;
  endproperty
  property p_flt_len; s_new ##0 cmd == CMD_READ && name == VAR_NAME[1] |=> rv2 == 16'h0000;
  endproperty
  property p_range; stat <= ST_TYPE; endproperty
  property p_gap_word; !fp_mode |-> in_img[INT_SLOT_WORDS] == 16'h0000; endproperty
  property p_reserved; fp_mode |-> out_img[0] == 16'h0000; endproperty

  a_null_stat: assert property (p_null_stat) else $error("status not null");
  a_answer: assert property (p_answer) else $error("no status for command");
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not flagged");
  a_bad_name: assert property (p_bad_name) else $error("bad name not flagged");
  a_prot: assert property (p_prot) else $error("protected write allowed");
  a_hold: assert property (p_hold) else $error("answer refreshed");
  a_no_rval: assert property (p_no_rval) else $error("read field not clear");
  a_int_len: assert property (p_int_len) else $error("integer read too long");
  a_flt_len: assert property (p_flt_len) else $error("float read too long");
  a_range: assert property (p_range) else $error("status code out of range");
  a_gap_word: assert property (p_gap_word) else $error("null word not zero");
  a_reserved: assert property (p_reserved) else $error("reserved word not zero");
endmodule : sva_link_chk

// *** dv/testbench.sv ***
// Bench joining both ends; software orders accesses over APB and checks both images.
// Assumes the variable table of the package; the layout goes to floating point at the end.
module testbench
  import sva_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         pclk, presetn, psel, penable, pwrite, var_upd, pready, pslverr, done, err;
  logic         fp_mode;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rdat;
  logic [1:0]   var_upd_idx;
  logic [159:0] var_upd_val;
  logic [15:0]  slot_word [SLOT_WORDS];
  logic [15:0]  stat;
  int           mismatches, tests_run;
  sva_if lnk();
  sva_dev i_sva_dev (.pclk(pclk), .presetn(presetn), .fp_mode(fp_mode), .slot_word(slot_word),
    .var_upd(var_upd), .var_upd_idx(var_upd_idx), .var_upd_val(var_upd_val), .link(lnk),
    .access_done_r(done), .access_status_r(stat));
  sva_plc i_sva_plc (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk));
  sva_link_chk u_chk (.pclk(pclk), .presetn(presetn), .fp_mode(fp_mode),
    .out_img(lnk.out_img), .in_img(lnk.in_img));

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The slave may stall during its null gap, so pready is polled, never counted.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, {16'h0000, e});
  endtask : rd

  // Name and value are loaded under a null command, then the command is raised.
  task run(input logic [47:0] nm, input logic [15:0] c, input logic [15:0] wv,
           input logic [15:0] e);
    int n;
    n = 0;
    wr(A_CMD, CMD_NULL);
    wr(A_NAME, nm[47:32]);
    wr(A_NAME + 8'h04, nm[31:16]);
    wr(A_NAME + 8'h08, nm[15:0]);
    wr(A_WVAL, wv);
    wr(A_CMD, c);
    do begin
      @(negedge pclk);
      n++;
    end while (done !== 1'b1 && n < 16);
    if (done !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
    chk({16'h0000, lnk.out_img[fp_mode ? FP_CMD_W : INT_CMD_W]}, {16'h0000, c});
    chk({16'h0000, lnk.in_img[fp_mode ? FP_STAT_W : INT_STAT_W]}, {16'h0000, e});
    chk({16'h0000, stat}, {16'h0000, e});
    rd(A_STAT, e);
  endtask : run

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    fp_mode = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    var_upd = 1'b0;
    var_upd_idx = 2'h0;
    var_upd_val = 160'h0;
    mismatches = 0;
    tests_run = 0;
    for (int i = 0; i < SLOT_WORDS; i++) slot_word[i] = 16'h0a00 + 16'(i);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_STAT, ST_NULL);
    apb(1'b0, 8'h70, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    for (int i = 0; i < 8; i++) chk({16'h0000, lnk.in_img[i]}, {16'h0000, slot_word[i]});
    run(VAR_NAME[3], CMD_WRITE, 16'h1234, ST_OK);
    rd(A_RVAL, 16'h0000);
    run(VAR_NAME[3], CMD_READ, 16'h0000, ST_OK);
    rd(A_RVAL, 16'h1234);
    rd(A_RVAL + 8'h04, 16'h0000);
    @(posedge pclk);
    var_upd <= 1'b1;
    var_upd_idx <= 2'h3;
    var_upd_val <= 160'h5555;
    @(posedge pclk);
    var_upd <= 1'b0;
    rd(A_RVAL, 16'h1234);
    run(VAR_NAME[3], CMD_READ, 16'h0000, ST_OK);
    rd(A_RVAL, 16'h5555);
    @(posedge pclk);
    var_upd <= 1'b1;
    var_upd_val <= 160'h6666;
    @(posedge pclk);
    var_upd <= 1'b0;
    // A read over a live read must pass through the controller's null gap to be taken.
    wr(A_CMD, CMD_READ);
    repeat (4) @(posedge pclk);
    rd(A_RVAL, 16'h6666);
    run(VAR_NAME[0], CMD_WRITE, 16'hc120, ST_PROT);
    run(VAR_NAME[0], CMD_READ, 16'h0000, ST_OK);
    rd(A_RVAL, 16'h0000);
    run(48'h7878_3031_3031, CMD_READ, 16'h0000, ST_NAME);
    run(VAR_NAME[3], 16'h0003, 16'h0000, ST_CMD);
    run(VAR_NAME[1], CMD_WRITE, 16'h6162, ST_TYPE);
    run(VAR_NAME[2], CMD_WRITE, 16'hc120, ST_TYPE);
    run(VAR_NAME[1], CMD_WRITE, 16'hc120, ST_OK);
    run(VAR_NAME[1], CMD_READ, 16'h0000, ST_OK);
    rd(A_RVAL, 16'hc120);
    rd(A_RVAL + 8'h08, 16'h0000);
    run(VAR_NAME[2], CMD_WRITE, 16'h6162, ST_OK);
    run(VAR_NAME[2], CMD_READ, 16'h0000, ST_OK);
    rd(A_RVAL, 16'h6162);
    wr(A_CMD, CMD_NULL);
    repeat (2) @(posedge pclk);
    rd(A_STAT, ST_NULL);
    // The layout moves to floating point only while the command is null.
    wr(A_FMT, 16'h0001);
    fp_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 16; i++) begin
      chk({16'h0000, lnk.in_img[i]}, {16'h0000, slot_word[i]});
    end
    chk({16'h0000, lnk.out_img[0]}, 32'h0000_0000);
    run(VAR_NAME[1], CMD_READ, 16'h0000, ST_OK);
    chk({16'h0000, lnk.in_img[FP_RVAL_W]}, 32'h0000_c120);
    rd(A_RVAL, 16'hc120);
    run(VAR_NAME[3], CMD_WRITE, 16'h2222, ST_OK);
    run(VAR_NAME[3], CMD_READ, 16'h0000, ST_OK);
    rd(A_RVAL, 16'h2222);
    give_verdict();
  end
endmodule : testbench

// *** logic/sva_dev.sv ***
// Device end: executes shared-variable commands found in the controller's output image.
// Assumes the controller image is synchronous to pclk and fp_mode changes only while the
// command word is null; var_upd comes from the terminal's own logic, never the controller.
//
// Contract
// - Controller may read and overwrite shared variables
// - Controller supplies command code and variable name
// - Write value supplied, at most 20 bytes
// - Read returns contents, at most 20 bytes
// - Type derived from name and stored definition
// - Refuse string-float and float-string writes
// - Status codes null, ok, bad name, bad command
// - Protected variable write refused with status 4
// - Read field valid only for read command
// - Command codes: 0 null, 1 read, 2 write
// - Execute once per change of command word
// - Read value is a snapshot, not refreshed
// - Repeat reads by toggling null and read
// - Load name and value while command null
// - Integer layout: slots, null, status, read value
// - Integer output: slots, command 8, name 10
// - Name is six ASCII characters, three words
// - Value length by type, at most ten words
// - Floats use IEEE 754 single precision
// - Status follows slots and null, value follows status (floating point has no null word: status at 16)
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
module sva_dev
  import sva_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          fp_mode,
  input  wire logic [15:0]   slot_word [SLOT_WORDS],
  input  wire logic          var_upd,
  input  wire logic [1:0]    var_upd_idx,
  input  wire logic [159:0]  var_upd_val,
  sva_if.dev                 link,
  output logic               access_done_r,
  output logic [15:0]        access_status_r
);
  logic [15:0]  cmd_prev_r;
  logic [159:0] val_r [NVAR];
  logic [159:0] rval_r;
  logic [159:0] rval_nxt;
  logic [15:0]  status_nxt;
  logic [15:0]  img_r   [IN_WORDS];
  logic [15:0]  img_nxt [IN_WORDS];
  logic [1:0]   idx;
  logic [159:0] wval_w;
  logic [159:0] len_mask_w;
  logic [NVAR-1:0] hit_vec;

  // Field selection by format.
  wire [15:0] cmd_w  = fp_mode ? link.out_img[FP_CMD_W] : link.out_img[INT_CMD_W];
  wire [47:0] name_w = fp_mode ?
    {link.out_img[FP_NAME_W], link.out_img[FP_NAME_W+1], link.out_img[FP_NAME_W+2]} :
    {link.out_img[INT_NAME_W], link.out_img[INT_NAME_W+1], link.out_img[INT_NAME_W+2]};

  genvar gi;
  generate
    for (gi = 0; gi < VAL_WORDS; gi++) begin : g_wval
      assign wval_w[gi*16 +: 16] = fp_mode ? link.out_img[FP_WVAL_W+gi]
                                           : link.out_img[INT_WVAL_W+gi];
    end
    for (gi = 0; gi < NVAR; gi++) begin : g_hit
      assign hit_vec[gi] = (name_w == VAR_NAME[gi]);
    end
  endgenerate

  // With no hit the index rests on zero; every use of it is gated by the hit flag.
  always_comb begin
    idx = 2'h0;
    for (int v = NVAR - 1; v >= 0; v--) begin
      if (hit_vec[v]) begin
        idx = 2'(v);
      end
    end
  end

  // The type comes only from the variable table; the image carries no type field.
  wire [1:0] type_w   = VAR_TYPE[idx];
  wire       hit_w    = |hit_vec;
  wire       new_w    = (cmd_w != cmd_prev_r);
  wire       is_null  = (cmd_w == CMD_NULL);
  wire       is_read  = (cmd_w == CMD_READ);
  wire       is_write = (cmd_w == CMD_WRITE);
  // String data is told apart by a printable first character. A float whose top byte is
  // printable is therefore refused as well; that is the price of having no type field.
  wire       str_data = (wval_w[15:8] >= ASCII_LO) && (wval_w[15:8] <= ASCII_HI);
  wire       type_bad = ((type_w == TY_FLOAT) && str_data) ||
                        ((type_w == TY_STR) && !str_data);
  wire       exec_w   = new_w && !is_null;
  wire       wr_ok    = exec_w && is_write && hit_w && !VAR_PROT[idx] && !type_bad;
  wire       rd_ok    = exec_w && is_read && hit_w;
  wire       bad_cmd  = !is_read && !is_write;
  wire       prot_hit = is_write && VAR_PROT[idx];
  wire       clash    = is_write && type_bad;
  wire       rval_clr = is_null || (new_w && (!is_read || !hit_w));

  // Words beyond the type's length are forced to zero so stale data never leaks out.
  generate
    for (gi = 0; gi < VAL_WORDS; gi++) begin : g_len
      assign len_mask_w[gi*16 +: 16] = (gi < TY_LEN[type_w]) ? 16'hffff : 16'h0000;
    end
  endgenerate

  // Faults are checked in a fixed order so one status word names the first of them.
  always_comb begin
    status_nxt = access_status_r;
    if (is_null) begin
      status_nxt = ST_NULL;
    end else if (new_w) begin
      if (bad_cmd) begin
        status_nxt = ST_CMD;
      end else if (!hit_w) begin
        status_nxt = ST_NAME;
      end else if (prot_hit) begin
        status_nxt = ST_PROT;
      end else if (clash) begin
        status_nxt = ST_TYPE;
      end else begin
        status_nxt = ST_OK;
      end
    end
  end

  // The read field is loaded once per read and cleared by any other command.
  always_comb begin
    rval_nxt = rval_r;
    if (rd_ok) begin
      rval_nxt = val_r[idx] & len_mask_w;
    end else if (rval_clr) begin
      rval_nxt = VAR_RST;
    end
  end

  // Input image assembly; floats pass through unchanged as IEEE single words.
  always_comb begin
    for (int w = 0; w < IN_WORDS; w++) begin
      img_nxt[w] = 16'h0000;
    end
    for (int s = 0; s < SLOT_WORDS; s++) begin
      if (fp_mode || (s < INT_SLOT_WORDS)) begin
        img_nxt[s] = slot_word[s];
      end
    end
    if (fp_mode) begin
      img_nxt[FP_STAT_W] = status_nxt;
      for (int r = 0; r < VAL_WORDS; r++) begin
        img_nxt[FP_RVAL_W+r] = rval_nxt[r*16 +: 16];
      end
    end else begin
      img_nxt[INT_STAT_W] = status_nxt;
      for (int r = 0; r < VAL_WORDS; r++) begin
        img_nxt[INT_RVAL_W+r] = rval_nxt[r*16 +: 16];
      end
    end
  end

  // The previous command word is the only memory of the change detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_prev_r    <= CMD_NULL;
      access_done_r <= 1'b0;
    end else begin
      cmd_prev_r    <= cmd_w;
      access_done_r <= exec_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rval_r          <= VAR_RST;
      access_status_r <= ST_NULL;
    end else begin
      rval_r          <= rval_nxt;
      access_status_r <= status_nxt;
    end
  end

  // A controller write wins over a local update of the same variable in the same cycle.
  generate
    for (gi = 0; gi < NVAR; gi++) begin : g_var
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          val_r[gi] <= VAR_RST;
        end else if (wr_ok && (idx == 2'(gi))) begin
          val_r[gi] <= wval_w & len_mask_w;
        end else if (var_upd && (var_upd_idx == 2'(gi))) begin
          val_r[gi] <= var_upd_val;
        end
      end
    end
  endgenerate

  // The whole reply image is registered, so slot words reach the controller a cycle late.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int w = 0; w < IN_WORDS; w++) begin
        img_r[w] <= 16'h0000;
      end
    end else begin
      img_r <= img_nxt;
    end
  end

  assign link.in_img = img_r;
endmodule : sva_dev

// *** logic/sva_if.sv ***
// Cyclic image carrier between the fieldbus controller and the device.
// Assumes both ends share one clock; each image is a registered word array.
interface sva_if;
  logic [15:0] out_img [28];
  logic [15:0] in_img  [27];
  modport dev (input out_img, output in_img);
  modport plc (output out_img, input in_img);
endinterface : sva_if

// *** logic/sva_pkg.sv ***
// Shared constants for the shared-variable access channel: image layout, codes, variables.
// Assumes a 16-bit word cyclic image exchanged once per clock between controller and device.
package sva_pkg;
  localparam int OUT_WORDS  = 28;
  localparam int IN_WORDS   = 27;
  localparam int VAL_WORDS  = 10;
  localparam int NVAR       = 4;
  localparam int SLOT_WORDS = 16;
  // Output image positions, integer/division and floating point, four slots.
  localparam int INT_CMD_W  = 8;
  localparam int INT_NAME_W = 10;
  localparam int INT_WVAL_W = 13;
  localparam int FP_CMD_W   = 13;
  localparam int FP_NAME_W  = 15;
  localparam int FP_WVAL_W  = 18;
  // Input image positions.
  localparam int INT_SLOT_WORDS = 8;
  localparam int INT_STAT_W     = 9;
  localparam int INT_RVAL_W     = 10;
  localparam int FP_STAT_W      = 16;
  localparam int FP_RVAL_W      = 17;
  // Command and status codes.
  localparam logic [15:0] CMD_NULL  = 16'h0000;
  localparam logic [15:0] CMD_READ  = 16'h0001;
  localparam logic [15:0] CMD_WRITE = 16'h0002;
  localparam logic [15:0] ST_NULL   = 16'h0000;
  localparam logic [15:0] ST_OK     = 16'h0001;
  localparam logic [15:0] ST_NAME   = 16'h0002;
  localparam logic [15:0] ST_CMD    = 16'h0003;
  localparam logic [15:0] ST_PROT   = 16'h0004;
  localparam logic [15:0] ST_TYPE   = 16'h0005;
  // Variable types and the number of value words each one carries.
  localparam logic [1:0] TY_INT   = 2'h0;
  localparam logic [1:0] TY_FLOAT = 2'h1;
  localparam logic [1:0] TY_STR   = 2'h2;
  localparam int TY_LEN [3] = '{1, 2, 10};
  localparam logic [7:0] ASCII_LO = 8'h20;
  localparam logic [7:0] ASCII_HI = 8'h7e;
  // Variable table: six ASCII characters, first character in the top byte.
  localparam logic [47:0] VAR_NAME [NVAR] = '{48'h7774_3031_3031, 48'h7774_3031_3032,
                                              48'h6473_3031_3031, 48'h6974_3031_3031};
  localparam logic [1:0] VAR_TYPE [NVAR] = '{TY_FLOAT, TY_FLOAT, TY_STR, TY_INT};
  localparam logic       VAR_PROT [NVAR] = '{1'b1, 1'b0, 1'b0, 1'b0};
  localparam logic [159:0] VAR_RST = 160'h0;
  // Controller register byte offsets on APB.
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_NAME = 8'h04;
  localparam logic [7:0] A_WVAL = 8'h10;
  localparam logic [7:0] A_FMT  = 8'h38;
  localparam logic [7:0] A_STAT = 8'h3c;
  localparam logic [7:0] A_RVAL = 8'h40;
  typedef enum logic [0:0] {SVA_IDLE = 1'b0, SVA_GAP = 1'b1} sva_hst_t;
endpackage : sva_pkg

// *** logic/sva_plc.sv ***
// Controller end: software orders shared-variable accesses through APB registers.
// Assumes an APB master on pclk; the device answers in the following image cycles.
module sva_plc
  import sva_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  sva_if.plc               link
);
  sva_hst_t    st_r;
  logic [15:0] cmd_r;
  logic [15:0] pend_r;
  logic [15:0] name_r [3];
  logic [15:0] wval_r [VAL_WORDS];
  logic        fmt_r;
  logic [15:0] img_r  [OUT_WORDS];
  logic [15:0] img_nxt [OUT_WORDS];
  logic [31:0] rd_nxt;
  logic        err_nxt;

  wire       st_idle = (st_r == SVA_IDLE);
  wire       done_w  = psel && penable && pready;
  wire       wr_w    = done_w && pwrite;
  wire [7:0] nm_off  = paddr - A_NAME;
  wire [7:0] wv_off  = paddr - A_WVAL;
  wire [7:0] rv_off  = paddr - A_RVAL;
  wire       in_name = (paddr >= A_NAME) && (paddr < A_WVAL) && (paddr[1:0] == 2'h0);
  wire       in_wval = (paddr >= A_WVAL) && (paddr < A_FMT) && (paddr[1:0] == 2'h0);
  wire       in_rval = (paddr >= A_RVAL) && (wv_off < 8'h28 + (A_RVAL - A_WVAL))
                       && (rv_off < 8'h28) && (paddr[1:0] == 2'h0);
  wire [4:0] stat_w  = fmt_r ? 5'(FP_STAT_W) : 5'(INT_STAT_W);
  wire [4:0] rbase_w = fmt_r ? 5'(FP_RVAL_W) : 5'(INT_RVAL_W);

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == A_CMD) begin
      rd_nxt[15:0] = cmd_r;
    end else if (in_name) begin
      rd_nxt[15:0] = name_r[nm_off[3:2]];
    end else if (in_wval) begin
      rd_nxt[15:0] = wval_r[wv_off[5:2]];
    end else if (paddr == A_FMT) begin
      rd_nxt[0] = fmt_r;
    end else if (paddr == A_STAT) begin
      rd_nxt[15:0] = link.in_img[stat_w];
    end else if (in_rval) begin
      rd_nxt[15:0] = link.in_img[rbase_w + 5'(rv_off[5:2])];
    end else begin
      err_nxt = 1'b1;
    end
  end

  // Output image layout; word 0 stays reserved in floating point.
  always_comb begin
    for (int w = 0; w < OUT_WORDS; w++) begin
      img_nxt[w] = 16'h0000;
    end
    img_nxt[fmt_r ? FP_CMD_W : INT_CMD_W] = cmd_r;
    for (int n = 0; n < 3; n++) begin
      img_nxt[(fmt_r ? FP_NAME_W : INT_NAME_W) + n] = name_r[n];
    end
    for (int v = 0; v < VAL_WORDS; v++) begin
      img_nxt[(fmt_r ? FP_WVAL_W : INT_WVAL_W) + v] = wval_r[v];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !pready && st_idle;
      prdata  <= rd_nxt;
      pslverr <= psel && !pready && st_idle && err_nxt;
    end
  end

  // A new command over a live one is preceded by one null cycle, so reads repeat.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= SVA_IDLE;
      cmd_r  <= CMD_NULL;
      pend_r <= CMD_NULL;
    end else if (!st_idle) begin
      cmd_r <= pend_r;
      st_r  <= SVA_IDLE;
    end else if (wr_w && (paddr == A_CMD)) begin
      if ((cmd_r != CMD_NULL) && (pwdata[15:0] != CMD_NULL)) begin
        cmd_r  <= CMD_NULL;
        pend_r <= pwdata[15:0];
        st_r   <= SVA_GAP;
      end else begin
        cmd_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_r <= 1'b0;
      for (int n = 0; n < 3; n++) begin
        name_r[n] <= 16'h0000;
      end
      for (int v = 0; v < VAL_WORDS; v++) begin
        wval_r[v] <= 16'h0000;
      end
      for (int w = 0; w < OUT_WORDS; w++) begin
        img_r[w] <= 16'h0000;
      end
    end else begin
      if (wr_w && (paddr == A_FMT)) begin
        fmt_r <= pwdata[0];
      end
      if (wr_w && in_name) begin
        name_r[nm_off[3:2]] <= pwdata[15:0];
      end
      if (wr_w && in_wval) begin
        wval_r[wv_off[5:2]] <= pwdata[15:0];
      end
      img_r <= img_nxt;
    end
  end

  assign link.out_img = img_r;
endmodule : sva_plc
